// file: core/lifar_bank.sv
// register bank for receiver enables, delay trims and fifo alarms
`include "lifar_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module lifar_bank (
    // clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    // serial register port, already decoded to word accesses
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [4:0] I_ADDR,
    input wire logic [15:0] I_WDATA,
    output logic [15:0] O_RDATA,
    // alarm controls from the neighbouring configuration register
    input wire logic I_TWO_APART_ALARM_ENABLE,
    input wire logic I_ONE_APART_ALARM_ENABLE,
    input wire logic I_COLLISION_ALARM_ENABLE,
    input wire logic I_ALARM_AUTO_CLEAR_ENABLE,
    // per-sample events from the datapath, one per clock
    input wire logic I_SAMPLE_VALID,
    input wire logic [13:0] I_PATTERN_MISMATCH,
    input wire lifar_pkg::lifar_fifo_evt_t I_FIFO_A_EVT,
    input wire lifar_pkg::lifar_fifo_evt_t I_FIFO_B_EVT,
    // configuration outputs
    output logic [13:0] O_RX_ENABLE,
    output lifar_pkg::lifar_delays_t O_DELAYS,
    output logic O_EXT_REF_ENABLE,
    output logic O_DUAL_CLOCK_ENABLE
);
    // register words and their next values
    logic [15:0] rx_enables;
    logic [15:0] next_rx_enables;
    logic [15:0] delay_ref;
    logic [15:0] next_delay_ref;
    logic [15:0] pattern_fail;
    logic [15:0] next_pattern_fail;
    logic [15:0] fifo_alarms;
    logic [15:0] next_fifo_alarms;
    logic [15:0] rdata;
    logic [15:0] next_rdata;
    // good-sample run counter
    logic [6:0] good_run;
    logic [6:0] next_good_run;
    lifar_pkg::lifar_run_t run_state;
    lifar_pkg::lifar_run_t next_run_state;
    // decoded write strobes and per-sample events
    logic wr_rx_enables;
    logic wr_delay_ref;
    logic wr_pattern_fail;
    logic wr_fifo_alarms;
    logic [2:0] code_a;
    logic [2:0] code_b;
    logic [15:0] pat_set;
    logic [15:0] fifo_set;
    logic sample_bad;
    logic auto_clear;

    // write strobe for one register address
    function automatic logic wr_hit(input logic wr, input logic [4:0] addr,
                                    input logic [4:0] target);
        return wr && (addr == target);
    endfunction : wr_hit

    // maps pointer events to the 3-bit status code, collision first
    function automatic logic [2:0] fifo_code(input lifar_pkg::lifar_fifo_evt_t evt,
                                             input logic en2, input logic en1,
                                             input logic enc);
        logic [2:0] code;
        code = 3'h0;
        if (evt.collision && enc) begin
            code = 3'h4;
        end else if (evt.one_apart && en1) begin
            code = 3'h2;
        end else if (evt.two_apart && en2) begin
            code = 3'h1;
        end
        return code;
    endfunction : fifo_code

    // sticky update; the clear goes first so a same-cycle event still lands
    function automatic logic [15:0] sticky_next(input logic [15:0] cur,
                                                input logic [15:0] evt_bits,
                                                input logic clr,
                                                input logic [15:0] mask);
        logic [15:0] kept;
        kept = clr ? 16'h0000 : cur;
        return (kept | evt_bits) & mask;
    endfunction : sticky_next

    // write strobes, one per register
    always_comb begin
        wr_rx_enables = wr_hit(I_WR, I_ADDR, `LIFAR_ADDR_RX_ENABLES);
        wr_delay_ref = wr_hit(I_WR, I_ADDR, `LIFAR_ADDR_DELAY_REF);
        wr_pattern_fail = wr_hit(I_WR, I_ADDR, `LIFAR_ADDR_PATTERN_FAIL);
        wr_fifo_alarms = wr_hit(I_WR, I_ADDR, `LIFAR_ADDR_FIFO_ALARMS);
    end

    // pointer status codes, gated by the alarm enables
    always_comb begin
        code_a = fifo_code(I_FIFO_A_EVT, I_TWO_APART_ALARM_ENABLE,
                           I_ONE_APART_ALARM_ENABLE,
                           I_COLLISION_ALARM_ENABLE);
        code_b = fifo_code(I_FIFO_B_EVT, I_TWO_APART_ALARM_ENABLE,
                           I_ONE_APART_ALARM_ENABLE,
                           I_COLLISION_ALARM_ENABLE);
    end

    // pattern bits picked up this cycle; invalid samples raise nothing
    always_comb begin
        pat_set = 16'h0000;
        if (I_SAMPLE_VALID) begin
            pat_set[13:0] = I_PATTERN_MISMATCH;
        end
    end

    // pointer alarm bits picked up this cycle
    always_comb begin
        fifo_set = 16'h0000;
        if (I_SAMPLE_VALID) begin
            fifo_set[`LIFAR_ZERO_A_BIT] = I_FIFO_A_EVT.zero_ptr;
            fifo_set[`LIFAR_ZERO_B_BIT] = I_FIFO_B_EVT.zero_ptr;
            fifo_set[`LIFAR_FIFOA_MSB:`LIFAR_FIFOA_LSB] = code_a;
            fifo_set[`LIFAR_FIFOB_MSB:`LIFAR_FIFOB_LSB] = code_b;
        end
    end

    // a sample is bad if any enabled alarm source would fire
    always_comb begin
        sample_bad = (|I_PATTERN_MISMATCH)
            || I_FIFO_A_EVT.zero_ptr
            || I_FIFO_B_EVT.zero_ptr
            || (code_a != 3'h0)
            || (code_b != 3'h0);
    end

    // good-sample run counter for automatic alarm clearing
    always_comb begin
        next_run_state = run_state;
        next_good_run = good_run;
        auto_clear = 1'b0;
        case (run_state)
            lifar_pkg::LIFAR_RUN_IDLE: begin
                next_good_run = 7'h00;
                if (I_ALARM_AUTO_CLEAR_ENABLE) begin
                    next_run_state = lifar_pkg::LIFAR_RUN_COUNT;
                end
            end
            lifar_pkg::LIFAR_RUN_COUNT: begin
                if (!I_ALARM_AUTO_CLEAR_ENABLE) begin
                    next_run_state = lifar_pkg::LIFAR_RUN_IDLE;
                    next_good_run = 7'h00;
                end else if (I_SAMPLE_VALID && sample_bad) begin
                    next_good_run = 7'h00;
                end else if (I_SAMPLE_VALID) begin
                    if (good_run == (`LIFAR_GOOD_RUN - 7'h01)) begin
                        auto_clear = 1'b1;
                        next_good_run = 7'h00;
                    end else begin
                        next_good_run = good_run + 7'h01;
                    end
                end
            end
            default: begin
                next_run_state = lifar_pkg::LIFAR_RUN_IDLE;
                next_good_run = 7'h00;
            end
        endcase
    end

    // run counter state
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            run_state <= lifar_pkg::LIFAR_RUN_IDLE;
            good_run <= 7'h00;
        end else begin
            run_state <= next_run_state;
            good_run <= next_good_run;
        end
    end

    // receiver enables: plain read/write, reserved bits masked off
    always_comb begin
        next_rx_enables = rx_enables;
        if (wr_rx_enables) begin
            next_rx_enables = I_WDATA & `LIFAR_MASK_RX_ENABLES;
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            rx_enables <= `LIFAR_RST_RX_ENABLES;
        end else begin
            rx_enables <= next_rx_enables;
        end
    end

    // delay trims, reference select and dual clock bit
    always_comb begin
        next_delay_ref = delay_ref;
        if (wr_delay_ref) begin
            next_delay_ref = I_WDATA & `LIFAR_MASK_DELAY_REF;
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            delay_ref <= `LIFAR_RST_DELAY_REF;
        end else begin
            delay_ref <= next_delay_ref;
        end
    end

    // pattern results; any written value clears the whole word
    always_comb begin
        next_pattern_fail = sticky_next(pattern_fail,
                                        pat_set,
                                        wr_pattern_fail || auto_clear,
                                        `LIFAR_MASK_PATTERN_FAIL);
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            pattern_fail <= `LIFAR_RST_PATTERN_FAIL;
        end else begin
            pattern_fail <= next_pattern_fail;
        end
    end

    // pointer alarms; cleared the same way as the pattern results
    always_comb begin
        next_fifo_alarms = sticky_next(fifo_alarms,
                                       fifo_set,
                                       wr_fifo_alarms || auto_clear,
                                       `LIFAR_MASK_FIFO_ALARMS);
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            fifo_alarms <= `LIFAR_RST_FIFO_ALARMS;
        end else begin
            fifo_alarms <= next_fifo_alarms;
        end
    end

    // read data is registered and holds until the next read strobe
    always_comb begin
        next_rdata = rdata;
        if (I_RD) begin
            case (I_ADDR)
                `LIFAR_ADDR_RX_ENABLES: begin
                    next_rdata = rx_enables;
                end
                `LIFAR_ADDR_DELAY_REF: begin
                    next_rdata = delay_ref;
                end
                `LIFAR_ADDR_PATTERN_FAIL: begin
                    next_rdata = pattern_fail;
                end
                `LIFAR_ADDR_FIFO_ALARMS: begin
                    next_rdata = fifo_alarms;
                end
                default: begin
                    next_rdata = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            rdata <= 16'h0000;
        end else begin
            rdata <= next_rdata;
        end
    end

    // configuration fields straight from the flops
    assign O_RDATA = rdata;
    assign O_RX_ENABLE = rx_enables[13:0];
    assign O_DELAYS.data_a = delay_ref[`LIFAR_DLYA_DATA_MSB:`LIFAR_DLYA_DATA_LSB];
    assign O_DELAYS.clk_a = delay_ref[`LIFAR_DLYA_CLK_MSB:`LIFAR_DLYA_CLK_LSB];
    assign O_DELAYS.data_b = delay_ref[`LIFAR_DLYB_DATA_MSB:`LIFAR_DLYB_DATA_LSB];
    assign O_DELAYS.clk_b = delay_ref[`LIFAR_DLYB_CLK_MSB:`LIFAR_DLYB_CLK_LSB];
    assign O_EXT_REF_ENABLE = delay_ref[`LIFAR_EXTREF_BIT];
    // passed on as stored; only valid when the host is in software-sync mode
    assign O_DUAL_CLOCK_ENABLE = delay_ref[`LIFAR_DUAL_CLK_BIT];
endmodule : lifar_bank
`default_nettype wire

// file: core/lifar_pkg.sv
// types shared by the register bank
package lifar_pkg;
    typedef struct packed {
        logic zero_ptr;
        logic collision;
        logic one_apart;
        logic two_apart;
    } lifar_fifo_evt_t;
    typedef struct packed {
        logic [2:0] data_a;
        logic [2:0] clk_a;
        logic [2:0] data_b;
        logic [2:0] clk_b;
    } lifar_delays_t;
    typedef enum logic [1:0] {
        LIFAR_RUN_IDLE = 2'b00,
        LIFAR_RUN_COUNT = 2'b01
    } lifar_run_t;
endpackage : lifar_pkg

// file: core/lifar_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef LIFAR_REGS_SVH
`define LIFAR_REGS_SVH
`define LIFAR_ADDR_RX_ENABLES 5'h02
`define LIFAR_ADDR_DELAY_REF 5'h03
`define LIFAR_ADDR_PATTERN_FAIL 5'h04
`define LIFAR_ADDR_FIFO_ALARMS 5'h05
`define LIFAR_RST_RX_ENABLES 16'h3FFF
`define LIFAR_RST_DELAY_REF 16'h0000
`define LIFAR_RST_PATTERN_FAIL 16'h0000
`define LIFAR_RST_FIFO_ALARMS 16'h0000
`define LIFAR_MASK_RX_ENABLES 16'h3FFF
`define LIFAR_MASK_DELAY_REF 16'hFFF9
`define LIFAR_MASK_PATTERN_FAIL 16'h3FFF
`define LIFAR_MASK_FIFO_ALARMS 16'hFF00
`define LIFAR_DLYA_DATA_MSB 15
`define LIFAR_DLYA_DATA_LSB 13
`define LIFAR_DLYA_CLK_MSB 12
`define LIFAR_DLYA_CLK_LSB 10
`define LIFAR_DLYB_DATA_MSB 9
`define LIFAR_DLYB_DATA_LSB 7
`define LIFAR_DLYB_CLK_MSB 6
`define LIFAR_DLYB_CLK_LSB 4
`define LIFAR_EXTREF_BIT 3
`define LIFAR_DUAL_CLK_BIT 0
`define LIFAR_ZERO_A_BIT 15
`define LIFAR_ZERO_B_BIT 14
`define LIFAR_FIFOA_MSB 13
`define LIFAR_FIFOA_LSB 11
`define LIFAR_FIFOB_MSB 10
`define LIFAR_FIFOB_LSB 8
`define LIFAR_GOOD_RUN 7'h40
`endif

// file: testbench/lifar_bank_props.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ps
`default_nettype none
module lifar_bank_props (
    // clock, reset, register port
    input wire logic I_REF_CLK,
    input wire logic I_RST,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [4:0] I_ADDR,
    input wire logic [15:0] I_WDATA,
    input wire logic [15:0] O_RDATA,
    // events
    input wire logic I_COLLISION_ALARM_ENABLE,
    input wire logic I_SAMPLE_VALID,
    input wire logic [13:0] I_PATTERN_MISMATCH,
    input wire lifar_pkg::lifar_fifo_evt_t I_FIFO_A_EVT,
    // configuration
    input wire logic [13:0] O_RX_ENABLE,
    input wire lifar_pkg::lifar_delays_t O_DELAYS,
    input wire logic O_EXT_REF_ENABLE,
    input wire logic O_DUAL_CLOCK_ENABLE
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);
    a_rx_write: assert property (I_WR && I_ADDR == 5'h02 |=> O_RX_ENABLE == $past(I_WDATA[13:0]))
        else $error("rx enable write");
    a_dly_write: assert property (I_WR && I_ADDR == 5'h03 |=> O_DELAYS == $past(I_WDATA[15:4]))
        else $error("delay write");
    a_ref_write: assert property (I_WR && I_ADDR == 5'h03 |=>
        {O_EXT_REF_ENABLE, O_DUAL_CLOCK_ENABLE} == {$past(I_WDATA[3]), $past(I_WDATA[0])})
        else $error("ref write");
    a_rx_read: assert property (I_RD && I_ADDR == 5'h02 |=> O_RDATA == {2'b00, $past(O_RX_ENABLE)})
        else $error("rx read");
    a_cfg_read: assert property (I_RD && I_ADDR == 5'h03 |=> O_RDATA ==
        {$past(O_DELAYS), $past(O_EXT_REF_ENABLE), 2'b00, $past(O_DUAL_CLOCK_ENABLE)})
        else $error("delay read");
    a_unmap_zero: assert property (I_RD && (I_ADDR < 5'h02 || I_ADDR > 5'h05) |=> O_RDATA == '0)
        else $error("unmapped read");
    a_fail_msb: assert property (I_SAMPLE_VALID && I_PATTERN_MISMATCH[13] ##1 I_RD && I_ADDR == 5'h04 |=> O_RDATA[13])
        else $error("mismatch bit");
    a_collide_code: assert property (I_SAMPLE_VALID && I_FIFO_A_EVT.collision && I_COLLISION_ALARM_ENABLE
        ##1 I_RD && I_ADDR == 5'h05 |=> O_RDATA[13]) else $error("collision code");
endmodule : lifar_bank_props
bind lifar_bank lifar_bank_props i_props (.*);
`default_nettype wire

// file: testbench/lifar_host.sv
// host model driving the serial register port
`timescale 1ns/1ps
`default_nettype none
module lifar_host (
    // clock
    input wire logic i_clk,
    // register port
    output logic o_wr,
    output logic o_rd,
    output logic [4:0] o_addr,
    output logic [15:0] o_wdata,
    input wire logic [15:0] i_rdata
);
    bit sync_mode = 1'b0;
    initial {o_wr, o_rd, o_addr, o_wdata} = '0;
    // one access, then an idle cycle so strobes never toggle in one step
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] q);
        o_wr = w;
        o_rd = !w;
        o_addr = a;
        o_wdata = (a == 5'h03 && !sync_mode) ? {d[15:1], 1'b0} : d;
        @(posedge i_clk) #1;
        q = i_rdata;
        {o_wr, o_rd} = 2'b00;
        @(posedge i_clk) #1;
    endtask : acc
endmodule : lifar_host
`default_nettype wire

// file: testbench/test_lvds_input_fifo_alarm_regs.sv
// self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module test_lvds_input_fifo_alarm_regs;
    logic clk = 1'b0, rst = 1'b1, wr, rd, ext, dual;
    logic en2 = 1'b1, en1 = 1'b1, enc = 1'b1, autoc = 1'b0, valid = 1'b0;
    logic [4:0] addr;
    logic [15:0] wdata, rdata, q;
    logic [13:0] mis = '0, rxen;
    lifar_pkg::lifar_fifo_evt_t ea = '0, eb = '0;
    lifar_pkg::lifar_delays_t dly;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    always #2 clk = ~clk;
    lifar_bank i_dut (.I_REF_CLK(clk), .I_RST(rst), .I_WR(wr), .I_RD(rd), .I_ADDR(addr),
        .I_WDATA(wdata), .O_RDATA(rdata), .I_TWO_APART_ALARM_ENABLE(en2),
        .I_ONE_APART_ALARM_ENABLE(en1), .I_COLLISION_ALARM_ENABLE(enc),
        .I_ALARM_AUTO_CLEAR_ENABLE(autoc), .I_SAMPLE_VALID(valid), .I_PATTERN_MISMATCH(mis),
        .I_FIFO_A_EVT(ea), .I_FIFO_B_EVT(eb), .O_RX_ENABLE(rxen), .O_DELAYS(dly),
        .O_EXT_REF_ENABLE(ext), .O_DUAL_CLOCK_ENABLE(dual));
    lifar_host i_host (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata),
        .i_rdata(rdata));
    task automatic give_verdict;
        if (error_cnt == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            give_verdict();
        end
    end
    task automatic chk_rd(input logic [4:0] a, input logic [15:0] e);
        i_host.acc(1'b0, a, 16'h0000, q);
        `CHK(q, e)
    endtask : chk_rd
    task automatic smp(input logic [13:0] m, input lifar_pkg::lifar_fifo_evt_t a, b);
        {valid, mis, ea, eb} = {1'b1, m, a, b};
        @(posedge clk) #1;
        {valid, mis, ea, eb} = '0;
    endtask : smp
    initial begin
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        @(posedge clk) #1;
        chk_rd(5'h02, 16'h3fff);
        chk_rd(5'h03, 16'h0000);
        chk_rd(5'h05, 16'h0000);
        i_host.acc(1'b1, 5'h02, 16'hfffc, q);
        chk_rd(5'h02, 16'h3ffc);
        `CHK(rxen, 14'h3ffc)
        i_host.sync_mode = 1'b1;
        i_host.acc(1'b1, 5'h03, 16'h7acf, q);
        chk_rd(5'h03, 16'h7ac9);
        `CHK({dly, ext, dual}, 14'h1eb3)
        i_host.acc(1'b1, 5'h06, 16'hffff, q);
        chk_rd(5'h06, 16'h0000);
        chk_rd(5'h1f, 16'h0000);
        smp(14'h2001, '0, '0);
        chk_rd(5'h04, 16'h2001);
        chk_rd(5'h04, 16'h2001);
        i_host.acc(1'b1, 5'h04, 16'h0000, q);
        chk_rd(5'h04, 16'h0000);
        // every code on both channels, then collision mixed with the others
        for (int i = 0; i < 5; i++) begin
            smp('0, (i == 4) ? 4'b0111 : 4'b0001 << i, (i == 4) ? 4'b0111 : 4'b0001 << i);
            chk_rd(5'h05, (i == 3) ? 16'hc000 : (i == 4) ? 16'h2400 : 16'h0900 << i);
            i_host.acc(1'b1, 5'h05, 16'hffff, q);
        end
        // each near alarm and the collision alarm alone, with only its own enable off
        for (int i = 0; i < 3; i++) begin
            {enc, en1, en2} = ~(3'b001 << i);
            smp('0, 4'b0001 << i, 4'b0001 << i);
            chk_rd(5'h05, 16'h0000);
        end
        {en2, en1, enc} = 3'b000;
        smp('0, 4'b0111, 4'b0111);
        chk_rd(5'h05, 16'h0000);
        {en2, en1, enc, autoc} = 4'b1111;
        // good run, a bad sample that restarts it, then 63 good ones: still held
        valid = 1'b1;
        repeat (10) @(posedge clk);
        #1 mis = 14'h0001;
        @(posedge clk) #1 mis = '0;
        repeat (63) @(posedge clk);
        #1 valid = 1'b0;
        chk_rd(5'h04, 16'h0001);
        smp('0, '0, '0);
        @(posedge clk) #1;
        chk_rd(5'h04, 16'h0000);
        // second reset in mid-run brings back the reset values of registers 02, 03 and 04 (05 is not read back)
        smp(14'h0004, '0, '0);
        rst = 1'b1;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        `CHK(rxen, 14'h3fff)
        `CHK({dly, ext, dual}, 14'h0000)
        @(posedge clk) #1;
        chk_rd(5'h02, 16'h3fff);
        chk_rd(5'h03, 16'h0000);
        chk_rd(5'h04, 16'h0000);
        give_verdict();
    end
endmodule : test_lvds_input_fifo_alarm_regs
`default_nettype wire
